/* File: hw/vop_pkg.sv */
// Notes on behaviour
// - two-bit timing field picks line-locked, simplified capture or capture port; 11 invalid
// - format 0010 16-bit 4:2:2 half rate, 0011 8-bit full, 0100 12-bit 4:1:1
// - force bit set three-states pixel drivers; clear lets output enable pin decide
// - vbi pass-through set: only active video processed, lines 1-21 minimally filtered
// - range bit clear clamps to studio range; set allows whole accessible range
// - chroma blanking bit set blanks both colour-difference samples during vertical blanking
// - lock option set puts horizontal lock status on general output pin 0
// - flag timing bit: flags follow external input clock (0) or internal clock (1)
// - low enable drives outputs 0 and 1, high enable outputs 2 and 3
// - writing 1 to fifo reset bit resets the fifo, bit then clears itself
// - auto reset bit set resets the fifo at the end of every field
// - revision bit selects embedded codes for revision 3 (0) or revision 4 (1)
package vop_pkg;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam int PIX_W = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_OUTPUT_MODE = 8'h03;
  localparam logic [7:0] IDX_EXT_OUTPUT = 8'h04;
  localparam logic [7:0] IDX_GP_OUTPUT = 8'h05;
  localparam logic [7:0] IDX_FIFO_CTRL = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h08;

  localparam logic [7:0] RST_OUTPUT_MODE = 8'h0c;
  localparam logic [7:0] RST_EXT_OUTPUT = 8'h0c;
  localparam logic [7:0] RST_GP_OUTPUT = 8'h00;
  localparam logic [4:0] RST_FIFO_MARGIN = 5'h04;
  localparam logic [2:0] EXT_RESERVED = 3'h6;

  // output mode register fields
  localparam int OM_TIMING_LSB = 0;
  localparam int OM_FORMAT_LSB = 2;
  localparam int OM_FORCE_TRI = 6;
  localparam int OM_VBI_PASS = 7;
  // extended output fields
  localparam int EX_RANGE = 0;
  localparam int EX_RSVD_LSB = 1;
  localparam int EX_EXTRA_LSB = 4;
  localparam int EX_REV4 = 7;
  // general output fields
  localparam int GP_BITS_LSB = 0;
  localparam int GP_EN_LOW = 4;
  localparam int GP_EN_HIGH = 5;
  localparam int GP_BLANK_C = 6;
  localparam int GP_LOCK_PIN0 = 7;
  // fifo control fields
  localparam int FC_MARGIN_LSB = 0;
  localparam int FC_MANUAL_RST = 5;
  localparam int FC_AUTO_RST = 6;
  localparam int FC_FLAG_TIMING = 7;

  localparam logic [1:0] TIM_LINE_LOCKED = 2'h0;
  localparam logic [1:0] TIM_SIMPLE_CAPTURE = 2'h1;
  localparam logic [1:0] TIM_CAPTURE = 2'h2;
  localparam logic [1:0] TIM_INVALID = 2'h3;
  localparam logic [3:0] FMT_16_422 = 4'h2;
  localparam logic [3:0] FMT_8_422 = 4'h3;
  localparam logic [3:0] FMT_12_411 = 4'h4;

  localparam logic [7:0] STUDIO_LO = 8'h10;
  localparam logic [7:0] STUDIO_Y_HI = 8'heb;
  localparam logic [7:0] STUDIO_C_HI = 8'hf0;
  localparam logic [7:0] FULL_LO = 8'h01;
  localparam logic [7:0] FULL_HI = 8'hfe;
  localparam logic [7:0] CHROMA_ZERO = 8'h80;

  typedef enum logic {PH_FIRST, PH_SECOND} vop_phase_type;
endpackage

/* File: hw/vop_fifo_if.sv */
interface vop_fifo_if import vop_pkg::*; ();
  logic push;
  logic [PIX_W-1:0] push_data;
  logic pop;
  logic [PIX_W-1:0] pop_data;
  logic full;
  logic empty;
  logic flush;
  logic flag_tick;
  logic [4:0] margin;
  logic almost_empty;
  logic almost_full;
  logic half_full;
  modport owner (output push, push_data, pop, flush, flag_tick, margin,
                 input pop_data, full, empty, almost_empty, almost_full, half_full);
  modport fifo (input push, push_data, pop, flush, flag_tick, margin,
                output pop_data, full, empty, almost_empty, almost_full, half_full);
endinterface

/* File: hw/vop_mem.sv */
module vop_mem #(
  parameter int W = 16,
  parameter int AW = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [W-1:0] rd_data_out
);
  logic [W-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

/* File: hw/vop_fifo.sv */
module vop_fifo import vop_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = FIFO_AW
) (
  input wire logic clk_in,
  input wire logic rst_in,
  vop_fifo_if.fifo port
);
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] level_q;
  logic do_push;
  logic do_pop;

  assign port.full = (level_q == (AW+1)'(DEPTH));
  assign port.empty = (level_q == '0);
  assign do_push = port.push & ~port.full & ~port.flush;
  assign do_pop = port.pop & ~port.empty & ~port.flush;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else if (port.flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        level_q <= level_q + 1'b1;
      end else if (do_pop && !do_push) begin
        level_q <= level_q - 1'b1;
      end
    end
  end

  // flags only move on the selected timing tick or a flush, so they stay steady between ticks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port.almost_empty <= 1'b1;
      port.almost_full <= 1'b0;
      port.half_full <= 1'b0;
    end else if (port.flush) begin
      port.almost_empty <= 1'b1;
      port.almost_full <= 1'b0;
      port.half_full <= 1'b0;
    end else if (port.flag_tick) begin
      port.almost_empty <= (level_q <= (AW+1)'(port.margin));
      port.almost_full <= (level_q >= (AW+1)'(DEPTH) - (AW+1)'(port.margin));
      port.half_full <= (level_q >= (AW+1)'(DEPTH / 2));
    end
  end

  vop_mem #(.W(PIX_W), .AW(AW)) u_mem (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(do_push),
    .wr_addr_in(wr_ptr_q),
    .wr_data_in(port.push_data),
    .rd_addr_in(rd_ptr_q),
    .rd_data_out(port.pop_data)
  );
endmodule

/* File: hw/vop_top.sv */
module vop_top import vop_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic pix_valid_in,
  input wire logic [7:0] pix_luma_in,
  input wire logic [7:0] pix_chroma_in,
  input wire logic vbi_line_in,
  input wire logic field_end_in,
  input wire logic line_locked_tick_in,
  input wire logic internal_27m_tick_in,
  output logic pix_ready_out,
  input wire logic output_enable_n_in,
  input wire logic hlock_in,
  input wire logic external_input_clock_in,
  output logic [PIX_W-1:0] pixel_data_out,
  output logic pixel_valid_out,
  output logic pixel_oe_out,
  output logic filter_bypass_out,
  output logic embedded_rev4_out,
  output logic [2:0] extra_data_select_out,
  output logic [1:0] output_timing_select_out,
  output logic [3:0] general_output_bits_out,
  output logic [3:0] general_output_oe_out,
  output logic almost_empty_flag_out,
  output logic almost_full_flag_out,
  output logic half_full_flag_out
);
  vop_fifo_if fifo_bus ();

  // register file
  logic [7:0] out_mode_q;
  logic [7:0] ext_out_q;
  logic [7:0] gp_out_q;
  logic [4:0] fifo_margin_q;
  logic fifo_manual_reset_q;
  logic fifo_field_auto_reset_q;
  logic fifo_flag_timing_select_q;
  logic ack_q;
  logic [31:0] readdata_q;
  logic [7:0] reg_idx;
  logic req;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;

  // pin synchronisers: oe_n, hlock, external clock
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic ext_clk_prev_q;
  logic oe_n_s;
  logic hlock_s;
  logic ext_clk_rise;

  // pixel path
  logic [7:0] luma_lim;
  logic [7:0] chroma_lim;
  logic [7:0] lo_lim;
  logic [7:0] y_hi_lim;
  logic [7:0] c_hi_lim;
  vop_phase_type phase_q;
  logic load_q;
  logic have_c_q;
  logic [7:0] c_hold_q;
  logic pop_now;
  logic [3:0] fmt;
  logic capture_mode;

  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign reg_idx = {2'b00, avs_address_in[7:2]};
  assign wr_fire = avs_write_in & ack_q & avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];
  assign avs_readdata_out = readdata_q;

  // one wait cycle lets read data settle in a register before it is taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (reg_idx)
      IDX_OUTPUT_MODE: rd_mux = out_mode_q;
      IDX_EXT_OUTPUT: rd_mux = {ext_out_q[7:4], EXT_RESERVED, ext_out_q[0]};
      IDX_GP_OUTPUT: rd_mux = gp_out_q;
      IDX_FIFO_CTRL: rd_mux = {fifo_flag_timing_select_q, fifo_field_auto_reset_q,
                               fifo_manual_reset_q, fifo_margin_q};
      IDX_STATUS: rd_mux = {3'h0, fifo_bus.empty, hlock_s, fifo_bus.half_full,
                            fifo_bus.almost_full, fifo_bus.almost_empty};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      readdata_q <= '0;
    end else if (avs_read_in && !ack_q) begin
      readdata_q <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_mode_q <= RST_OUTPUT_MODE;
    end else if (wr_fire && reg_idx == IDX_OUTPUT_MODE) begin
      out_mode_q[OM_FORCE_TRI] <= wbyte[OM_FORCE_TRI];
      out_mode_q[OM_VBI_PASS] <= wbyte[OM_VBI_PASS];
      // the invalid timing code is refused so the port never runs undefined
      if (wbyte[OM_TIMING_LSB +: 2] != TIM_INVALID) begin
        out_mode_q[OM_TIMING_LSB +: 2] <= wbyte[OM_TIMING_LSB +: 2];
      end
      if (wbyte[OM_FORMAT_LSB +: 4] == FMT_16_422 || wbyte[OM_FORMAT_LSB +: 4] == FMT_8_422 ||
          wbyte[OM_FORMAT_LSB +: 4] == FMT_12_411) begin
        out_mode_q[OM_FORMAT_LSB +: 4] <= wbyte[OM_FORMAT_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_out_q <= RST_EXT_OUTPUT;
    end else if (wr_fire && reg_idx == IDX_EXT_OUTPUT) begin
      // reserved bits are not stored; they always read back as their default
      ext_out_q <= {wbyte[7:4], EXT_RESERVED, wbyte[0]};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gp_out_q <= RST_GP_OUTPUT;
    end else if (wr_fire && reg_idx == IDX_GP_OUTPUT) begin
      gp_out_q <= wbyte;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_margin_q <= RST_FIFO_MARGIN;
      fifo_field_auto_reset_q <= 1'b0;
      fifo_flag_timing_select_q <= 1'b0;
    end else if (wr_fire && reg_idx == IDX_FIFO_CTRL) begin
      fifo_margin_q <= wbyte[FC_MARGIN_LSB +: 5];
      fifo_field_auto_reset_q <= wbyte[FC_AUTO_RST];
      fifo_flag_timing_select_q <= wbyte[FC_FLAG_TIMING];
    end
  end

  // self-clearing: stands one cycle, flushes the fifo, then drops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_manual_reset_q <= 1'b0;
    end else begin
      fifo_manual_reset_q <= wr_fire && reg_idx == IDX_FIFO_CTRL && wbyte[FC_MANUAL_RST];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 3'h1;
      sync2_q <= 3'h1;
      ext_clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {external_input_clock_in, hlock_in, output_enable_n_in};
      sync2_q <= sync1_q;
      ext_clk_prev_q <= sync2_q[2];
    end
  end

  assign oe_n_s = sync2_q[0];
  assign hlock_s = sync2_q[1];
  assign ext_clk_rise = sync2_q[2] & ~ext_clk_prev_q;

  assign fifo_bus.flush = fifo_manual_reset_q | (fifo_field_auto_reset_q & field_end_in);
  assign fifo_bus.flag_tick = fifo_flag_timing_select_q ? internal_27m_tick_in : ext_clk_rise;
  assign fifo_bus.margin = fifo_margin_q;

  // intake: clamp codes, optionally blank chroma in blanking
  always_comb begin
    lo_lim = STUDIO_LO;
    y_hi_lim = STUDIO_Y_HI;
    c_hi_lim = STUDIO_C_HI;
    if (ext_out_q[EX_RANGE]) begin
      // 00 and ff stay reserved for the timing codes even in full range
      lo_lim = FULL_LO;
      y_hi_lim = FULL_HI;
      c_hi_lim = FULL_HI;
    end
    luma_lim = pix_luma_in;
    if (pix_luma_in < lo_lim) begin
      luma_lim = lo_lim;
    end else if (pix_luma_in > y_hi_lim) begin
      luma_lim = y_hi_lim;
    end
    chroma_lim = pix_chroma_in;
    if (pix_chroma_in < lo_lim) begin
      chroma_lim = lo_lim;
    end else if (pix_chroma_in > c_hi_lim) begin
      chroma_lim = c_hi_lim;
    end
    if (gp_out_q[GP_BLANK_C] && vbi_line_in) begin
      chroma_lim = CHROMA_ZERO;
    end
  end

  assign fifo_bus.push = pix_valid_in;
  assign fifo_bus.push_data = {luma_lim, chroma_lim};
  assign pix_ready_out = ~fifo_bus.full;

  // output formatter on the line-locked tick
  assign fmt = out_mode_q[OM_FORMAT_LSB +: 4];
  assign capture_mode = out_mode_q[OM_TIMING_LSB +: 2] == TIM_SIMPLE_CAPTURE ||
                        out_mode_q[OM_TIMING_LSB +: 2] == TIM_CAPTURE;
  // 8-bit pops on the first phase and sends chroma on the second; others pop at half rate
  assign pop_now = line_locked_tick_in & ~fifo_bus.empty &
                   ((fmt == FMT_8_422) ? (phase_q == PH_FIRST) : (phase_q == PH_SECOND));
  assign fifo_bus.pop = pop_now;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= PH_FIRST;
    end else if (fifo_bus.flush) begin
      phase_q <= PH_FIRST;
    end else if (line_locked_tick_in) begin
      case (phase_q)
        PH_FIRST: phase_q <= PH_SECOND;
        PH_SECOND: phase_q <= PH_FIRST;
        default: phase_q <= PH_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_q <= 1'b0;
    end else begin
      load_q <= pop_now & ~fifo_bus.flush;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pixel_data_out <= '0;
      c_hold_q <= 8'h00;
      have_c_q <= 1'b0;
      pixel_valid_out <= 1'b0;
    end else begin
      pixel_valid_out <= 1'b0;
      if (load_q) begin
        pixel_valid_out <= capture_mode;
        case (fmt)
          FMT_16_422: pixel_data_out <= fifo_bus.pop_data;
          FMT_8_422: begin
            pixel_data_out <= {8'h00, fifo_bus.pop_data[15:8]};
            c_hold_q <= fifo_bus.pop_data[7:0];
            have_c_q <= 1'b1;
          end
          FMT_12_411: pixel_data_out <= {4'h0, fifo_bus.pop_data[7:4],
                                         fifo_bus.pop_data[15:8]};
          default: pixel_data_out <= fifo_bus.pop_data;
        endcase
      end else if (have_c_q && line_locked_tick_in && phase_q == PH_SECOND) begin
        pixel_data_out <= {8'h00, c_hold_q};
        have_c_q <= 1'b0;
        pixel_valid_out <= capture_mode;
      end
    end
  end

  assign pixel_oe_out = ~out_mode_q[OM_FORCE_TRI] & ~oe_n_s;
  assign filter_bypass_out = out_mode_q[OM_VBI_PASS] & vbi_line_in;
  assign embedded_rev4_out = ext_out_q[EX_REV4];
  assign extra_data_select_out = ext_out_q[EX_EXTRA_LSB +: 3];
  assign output_timing_select_out = out_mode_q[OM_TIMING_LSB +: 2];

  assign general_output_bits_out = {gp_out_q[GP_BITS_LSB + 3], gp_out_q[GP_BITS_LSB + 2],
                                    gp_out_q[GP_BITS_LSB + 1],
                                    gp_out_q[GP_LOCK_PIN0] ? hlock_s
                                                           : gp_out_q[GP_BITS_LSB]};
  assign general_output_oe_out = {{2{gp_out_q[GP_EN_HIGH]}}, {2{gp_out_q[GP_EN_LOW]}}};

  // flags leave the chip only when a capture mode asks for them
  assign almost_empty_flag_out = capture_mode & fifo_bus.almost_empty;
  assign almost_full_flag_out = capture_mode & fifo_bus.almost_full;
  assign half_full_flag_out = capture_mode & fifo_bus.half_full;

  vop_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .port(fifo_bus.fifo)
  );
endmodule

/* File: testbench/vop_top_props.sv */
module vop_top_props import vop_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic vbi_line_in,
  input wire logic output_enable_n_in,
  input wire logic hlock_in,
  input wire logic pixel_oe_out,
  input wire logic filter_bypass_out,
  input wire logic embedded_rev4_out,
  input wire logic [1:0] output_timing_select_out,
  input wire logic [3:0] general_output_bits_out,
  input wire logic [3:0] general_output_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mode_q;
  logic rev4_q;
  logic [7:0] gp_q;
  logic wr_ok;
  logic rd_ok;
  // shadows follow accepted writes, so pin checks need no view inside
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign rd_ok = avs_read_in && !avs_waitrequest_out;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= 2'h0;
    end else if (wr_ok && avs_address_in[7:2] == IDX_OUTPUT_MODE[5:0]) begin
      mode_q <= avs_writedata_in[7:6];
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rev4_q <= 1'b0;
    end else if (wr_ok && avs_address_in[7:2] == IDX_EXT_OUTPUT[5:0]) begin
      rev4_q <= avs_writedata_in[7];
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gp_q <= 8'h00;
    end else if (wr_ok && avs_address_in[7:2] == IDX_GP_OUTPUT[5:0]) begin
      gp_q <= avs_writedata_in[7:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |-> s_one_wait)
    else $error("bus wait not one cycle");
  AST_IDLE_NO_WAIT: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait without request");
  AST_TIMING_VALID: assert property (output_timing_select_out != TIM_INVALID)
    else $error("invalid timing select");
  AST_FORCE_TRI: assert property (mode_q[0] |-> !pixel_oe_out)
    else $error("pixel drivers on while forced off");
  AST_OE_FOLLOW: assert property (!mode_q[0] |-> pixel_oe_out == !$past(output_enable_n_in, 2))
    else $error("pixel drivers not following enable pin");
  AST_BYPASS: assert property (filter_bypass_out == (mode_q[1] && vbi_line_in))
    else $error("filter bypass wrong");
  AST_LOCK_PIN0: assert property (general_output_bits_out[0] == (gp_q[7] ? $past(hlock_in, 2) : gp_q[0]))
    else $error("general pin 0 wrong");
  AST_GPO_BITS: assert property (general_output_bits_out[3:1] == gp_q[3:1])
    else $error("general pins 3 to 1 wrong");
  AST_GPO_OE: assert property (general_output_oe_out == {{2{gp_q[5]}}, {2{gp_q[4]}}})
    else $error("general pin drive enables wrong");
  AST_FR_CLEAR: assert property (rd_ok && avs_address_in[7:2] == IDX_FIFO_CTRL[5:0] |-> !avs_readdata_out[5])
    else $error("fifo reset bit did not clear");
  AST_REV4: assert property (embedded_rev4_out == rev4_q)
    else $error("revision select wrong");
endmodule

bind vop_top vop_top_props vop_top_props_inst (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .vbi_line_in, .output_enable_n_in, .hlock_in, .pixel_oe_out, .filter_bypass_out,
  .embedded_rev4_out, .output_timing_select_out, .general_output_bits_out,
  .general_output_oe_out);

/* File: testbench/vop_backend_model.sv */
module vop_backend_model import vop_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pixel_valid_in,
  input wire logic [PIX_W-1:0] pixel_data_in,
  output logic [PIX_W-1:0] word_out,
  output int count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // the back-end cannot stall this port, so every valid pulse is taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_out <= '0;
      count_out <= 0;
    end else if (pixel_valid_in) begin
      word_out <= pixel_data_in;
      count_out <= count_out + 1;
    end
  end
endmodule

/* File: testbench/vop_top_tb.sv */
module vop_top_tb import vop_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} vop_row_type;
  typedef struct packed {
    logic oe; logic byp; logic rev4; logic rdy; logic [3:0] gb; logic [3:0] go;
    logic [2:0] fl; logic [2:0] xs;
  } vop_snap_type;
  logic clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out, tick_en;
  logic pix_valid_in, vbi_line_in, field_end_in;
  logic line_locked_tick_in = 1'b0, internal_27m_tick_in = 1'b0;
  logic pix_ready_out, output_enable_n_in, hlock_in, external_input_clock_in;
  logic pixel_valid_out, pixel_oe_out, filter_bypass_out, embedded_rev4_out;
  logic almost_empty_flag_out, almost_full_flag_out, half_full_flag_out;
  logic [7:0] avs_address_in, pix_luma_in, pix_chroma_in, rd;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in, general_output_bits_out, general_output_oe_out;
  logic [2:0] extra_data_select_out;
  logic [1:0] output_timing_select_out, tcnt = 2'h0;
  logic [PIX_W-1:0] pixel_data_out, cap_word;
  int cap_count, bad_count, n_compared;
  vop_snap_type snap;
  vop_row_type rows [10] = '{
    '{8'h0c, 8'h0a, 8'h0a}, '{8'h0c, 8'h0f, 8'h0e}, '{8'h0c, 8'h15, 8'h0d},
    '{8'h0c, 8'h11, 8'h11}, '{8'h10, 8'hfd, 8'hfd}, '{8'h10, 8'h0c, 8'h0c},
    '{8'h14, 8'ha5, 8'ha5}, '{8'h1c, 8'h5f, 8'h5f}, '{8'h1c, 8'h24, 8'h04},
    '{8'h3c, 8'hff, 8'h00}};

  vop_top vop_top_inst (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .pix_valid_in, .pix_luma_in, .pix_chroma_in, .vbi_line_in, .field_end_in,
    .line_locked_tick_in, .internal_27m_tick_in, .pix_ready_out, .output_enable_n_in,
    .hlock_in, .external_input_clock_in, .pixel_data_out, .pixel_valid_out, .pixel_oe_out,
    .filter_bypass_out, .embedded_rev4_out, .extra_data_select_out, .output_timing_select_out,
    .general_output_bits_out, .general_output_oe_out, .almost_empty_flag_out,
    .almost_full_flag_out, .half_full_flag_out);
  vop_backend_model vop_backend_model_inst (.clk_in, .rst_in, .pixel_valid_in(pixel_valid_out),
    .pixel_data_in(pixel_data_out), .word_out(cap_word), .count_out(cap_count));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    tcnt <= tcnt + 2'h1;
    line_locked_tick_in <= tick_en && tcnt == 2'h3;
    internal_27m_tick_in <= tcnt[0];
  end
  // snapshot at the falling edge keeps output reads clear of edge races
  always @(negedge clk_in) begin
    snap <= {pixel_oe_out, filter_bypass_out, embedded_rev4_out, pix_ready_out,
      general_output_bits_out, general_output_oe_out, almost_empty_flag_out,
      almost_full_flag_out, half_full_flag_out, extra_data_select_out};
  end

  task automatic fail(input string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("register %h want %h", g, e));
  endtask
  task automatic chk_pix(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("pixel %h want %h", g, e));
  endtask
  task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("pins %h want %h", g, e));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, wd};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge clk_in);
    end
    rd = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic push(input logic [7:0] y, input logic [7:0] c);
    pix_luma_in <= y;
    pix_chroma_in <= c;
    pix_valid_in <= 1'b1;
    @(posedge clk_in);
    pix_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic send(input logic [7:0] y, input logic [7:0] c, input logic [15:0] e);
    int k;
    k = cap_count;
    push(y, c);
    repeat (40) if (cap_count == k) @(negedge clk_in);
    @(posedge clk_in);
    chk_pin({3'h0, cap_count != k}, 4'h1);
    chk_pix(cap_word, e);
  endtask
  task automatic field_pulse();
    field_end_in <= 1'b1;
    @(posedge clk_in);
    field_end_in <= 1'b0;
    cyc(4);
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fail("watchdog");
    results();
  end

  initial begin
    {avs_read_in, avs_write_in, pix_valid_in, vbi_line_in, field_end_in, hlock_in} = '0;
    {external_input_clock_in, tick_en} = '0;
    {avs_address_in, avs_writedata_in, pix_luma_in, pix_chroma_in} = '0;
    avs_byteenable_in = 4'h1;
    output_enable_n_in = 1'b1;
    bad_count = 0;
    n_compared = 0;
    rst_in = 1'b1;
    cyc(10);
    rst_in <= 1'b0;
    @(posedge clk_in);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 8'h00);
      chk_reg(rd, rows[i].e);
    end
    $display("test registers done");
    output_enable_n_in <= 1'b0;
    vbi_line_in <= 1'b1;
    bus(1'b1, 8'h0c, 8'h4a);
    chk_pin({2'h0, snap.oe, snap.byp}, 4'h0);
    bus(1'b1, 8'h0c, 8'h8a);
    chk_pin({2'h0, snap.oe, snap.byp}, 4'h3);
    vbi_line_in <= 1'b0;
    output_enable_n_in <= 1'b1;
    bus(1'b1, 8'h0c, 8'h0a);
    chk_pin({2'h0, snap.oe, snap.byp}, 4'h0);
    hlock_in <= 1'b1;
    bus(1'b1, 8'h14, 8'hbe);
    chk_pin(snap.gb, 4'hf);
    chk_pin(snap.go, 4'hf);
    hlock_in <= 1'b0;
    bus(1'b1, 8'h14, 8'h21);
    chk_pin(snap.gb, 4'h1);
    chk_pin(snap.go, 4'hc);
    bus(1'b1, 8'h10, 8'hdc);
    chk_pin({snap.rev4, snap.xs}, 4'hd);
    $display("test pins done");
    tick_en <= 1'b1;
    bus(1'b1, 8'h10, 8'h0c);
    send(8'h05, 8'h80, 16'h1080);
    send(8'hf0, 8'hf8, 16'hebf0);
    bus(1'b1, 8'h10, 8'h0d);
    send(8'h00, 8'hff, 16'h01fe);
    bus(1'b1, 8'h14, 8'h40);
    vbi_line_in <= 1'b1;
    send(8'h50, 8'h33, 16'h5080);
    vbi_line_in <= 1'b0;
    send(8'h50, 8'h33, 16'h5033);
    bus(1'b1, 8'h0c, 8'h12);
    send(8'h50, 8'ha3, 16'h0a50);
    bus(1'b1, 8'h0c, 8'h0e);
    send(8'h50, 8'h33, 16'h0050);
    cyc(8);
    chk_pix(cap_word, 16'h0033);
    $display("test pixels done");
    tick_en <= 1'b0;
    bus(1'b1, 8'h1c, 8'h24);
    repeat (20) push(8'h40, 8'h80);
    cyc(10);
    chk_pin({1'b0, snap.fl}, 4'h4);
    external_input_clock_in <= 1'b1;
    cyc(6);
    chk_pin({1'b0, snap.fl}, 4'h1);
    external_input_clock_in <= 1'b0;
    bus(1'b1, 8'h1c, 8'h84);
    repeat (7) push(8'h40, 8'h80);
    cyc(4);
    chk_pin({snap.rdy, snap.fl}, 4'h9);
    push(8'h40, 8'h80);
    cyc(4);
    chk_pin({snap.rdy, snap.fl}, 4'hb);
    repeat (5) push(8'h40, 8'h80);
    field_pulse();
    chk_pin({snap.rdy, snap.fl}, 4'h3);
    bus(1'b1, 8'h1c, 8'hc4);
    field_pulse();
    chk_pin({snap.rdy, snap.fl}, 4'hc);
    bus(1'b1, 8'h1c, 8'h84);
    repeat (20) push(8'h40, 8'h80);
    bus(1'b1, 8'h1c, 8'ha4);
    cyc(4);
    chk_pin({snap.rdy, snap.fl}, 4'hc);
    $display("test fifo done");
    rst_in <= 1'b1;
    cyc(3);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(1'b0, 8'h0c, 8'h00);
    chk_reg(rd, RST_OUTPUT_MODE);
    bus(1'b0, 8'h10, 8'h00);
    chk_reg(rd, RST_EXT_OUTPUT);
    bus(1'b0, 8'h14, 8'h00);
    chk_reg(rd, RST_GP_OUTPUT);
    bus(1'b0, 8'h1c, 8'h00);
    chk_reg(rd, {3'h0, RST_FIFO_MARGIN});
    $display("test reset done");
    results();
  end
endmodule
